// ---- hw/pcc_map.svh ----
// constants of the clock and power-down controller
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCC_CSR_OFS        12'h000
`define PCC_IER_OFS        12'h004
`define PCC_CFG_OFS        12'h008
`define PCC_STAT_OFS       12'h00C
`define PCC_WAKE_OFS       12'h010

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define PCC_PD_LSB         10
`define PCC_PD_MSB         15
`define PCC_GIE_BIT        0
`define PCC_NMI_ENABLE_BIT_BIT       1
`define PCC_CODE_NONE      6'h00
`define PCC_CODE_SLP_EN    6'h09
`define PCC_CODE_SLP_ANY   6'h11
`define PCC_CODE_OUT_STOP  6'h1A
`define PCC_CODE_IN_STOP   6'h1C
`define PCC_RANGE_MAX      3'h2
`define PCC_CSR_RST        32'h0000_0000
`define PCC_CFG_RST        32'h0000_0001

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCC_CLK_NS         10
`define PCC_SLEEP_DLY      4'h8
`define PCC_LOCK_TYP_US    75
`define PCC_LOCK_MAX_NS    (`PCC_LOCK_TYP_US * 1000 * 250 / 100)
`define PCC_LOCK_CYC       (`PCC_LOCK_MAX_NS / `PCC_CLK_NS)

`endif

// ---- hw/pcc_pkg.sv ----
// types of the clock and power-down controller
package pcc_pkg;

  typedef enum logic [2:0] {
    PCC_RUN,
    PCC_ARM,
    PCC_SLEEP,
    PCC_OUT_STOP,
    PCC_IN_STOP,
    PCC_LOCK
  } pcc_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pcc_wr_s;

  typedef struct packed {
    logic        cpu_ce;
    logic        half_ce;
    logic        div_ph;
  } pcc_clk_s;

endpackage : pcc_pkg

// ---- hw/pcc_clkdiv.sv ----
// clock enable generator: x1 bypass or x4 multiply, half-rate output
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"
module pcc_clkdiv
  import pcc_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     arst_n,
  input  wire logic     ref_clock_in,
  input  wire logic     pll_multiplier_select,
  input  wire logic     run_en,
  output pcc_clk_s      clk_o
);
  pcc_clk_s st_reg;
  pcc_clk_s st_next;
  logic     ref_d_reg;
  logic     ref_rise;
  logic     tick;

  assign ref_rise = ref_clock_in & ~ref_d_reg;
  // x4: every mclk is a cpu cycle; x1: one per rising reference edge
  assign tick = pll_multiplier_select ? 1'b1 : ref_rise;

  always_comb begin
    st_next = st_reg;
    st_next.cpu_ce  = run_en & tick;
    st_next.half_ce = run_en & tick & st_reg.div_ph;
    if (run_en && tick) begin
      st_next.div_ph = ~st_reg.div_ph;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg    <= '0;
      ref_d_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      ref_d_reg <= ref_clock_in;
    end
  end

  assign clk_o = st_reg;
endmodule : pcc_clkdiv
`default_nettype wire

// ---- hw/pcc_lockwait.sv ----
// PLL lock wait counter
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"
module pcc_lockwait #(
  parameter int unsigned LOCK_CYC = `PCC_LOCK_CYC
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic start,
  output logic      locked
);
  logic [15:0] cnt_reg;
  logic        locked_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg    <= 16'h0000;
      locked_reg <= 1'b0;
    end else if (start) begin
      cnt_reg    <= 16'h0000;
      locked_reg <= 1'b0;
    end else if (!locked_reg) begin
      cnt_reg <= cnt_reg + 16'h0001;
      if (cnt_reg == 16'(LOCK_CYC - 1)) begin
        locked_reg <= 1'b1;
      end
    end
  end

  assign locked = locked_reg;
endmodule : pcc_lockwait
`default_nettype wire

// ---- hw/pcc_top.sv ----
// clock and power-down controller with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pcc_map.svh"
module pcc_top
  import pcc_pkg::*;
#(
  parameter int unsigned LOCK_CYC = `PCC_LOCK_CYC
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        ref_clock_in,
  input  wire logic        int_enabled,
  input  wire logic        int_any,
  input  wire logic        dma_req,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_clock_out,
  output logic             half_rate_clock_out,
  output logic             cpu_clk_en,
  output logic             dma_clk_en,
  output logic             isr_req,
  output logic             resume_req
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pcc_state_e  fsm;
    logic [31:0] control_status_reg;
    logic [31:0] int_enable_reg;
    logic        pll_multiplier_select;
    logic [2:0]  pll_range_select;
    logic [3:0]  dly;
    logic        lock_start;
    logic        aw_got;
    logic        w_got;
    logic        awready;
    logic        wready;
    pcc_wr_s     wr;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        cpu_out;
    logic        half_out;
    logic        cpu_en;
    logic        dma_en;
    logic        isr;
    logic        resume;
    logic        wake_isr;
    logic        wake_seen;
  } pcc_st_s;

  pcc_st_s  st_reg;
  pcc_st_s  st_next;
  pcc_clk_s clk_s;
  logic     locked;
  logic     running;
  logic     wr_go;
  logic [5:0] pd_code;
  logic     int_ok;
  logic     csr_wr;
  logic     lock_restart;

  // ----------------------------------------------------------------
  // register word indices and reset values
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_CSR  = 10'(`PCC_CSR_OFS >> 2);
  localparam logic [9:0]  IDX_IER  = 10'(`PCC_IER_OFS >> 2);
  localparam logic [9:0]  IDX_CFG  = 10'(`PCC_CFG_OFS >> 2);
  localparam logic [9:0]  IDX_STAT = 10'(`PCC_STAT_OFS >> 2);
  localparam logic [9:0]  IDX_WAKE = 10'(`PCC_WAKE_OFS >> 2);
  localparam logic [31:0] CFG_RST  = `PCC_CFG_RST;

  assign running = (st_reg.fsm == PCC_RUN) || (st_reg.fsm == PCC_ARM);
  assign wr_go   = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign pd_code = st_reg.control_status_reg[`PCC_PD_MSB:`PCC_PD_LSB];
  assign int_ok  = st_reg.control_status_reg[`PCC_GIE_BIT]
                 & st_reg.int_enable_reg[`PCC_NMI_ENABLE_BIT_BIT];
  // write of the power-down field arms the sequencer
  assign csr_wr       = wr_go && (st_reg.wr.addr[11:2] == IDX_CSR)
                      && st_reg.wr.strb[1];
  // cfg write with x4 set restarts the lock wait
  assign lock_restart = wr_go && (st_reg.wr.addr[11:2] == IDX_CFG)
                      && st_reg.wr.strb[0] && st_reg.wr.data[0];

  pcc_clkdiv u_div (
    .mclk                  (mclk),
    .arst_n                (arst_n),
    .ref_clock_in          (ref_clock_in),
    .pll_multiplier_select (st_reg.pll_multiplier_select),
    .run_en                (running && locked),
    .clk_o                 (clk_s)
  );

  pcc_lockwait #(
    .LOCK_CYC (LOCK_CYC)
  ) u_lock (
    .mclk   (mclk),
    .arst_n (arst_n),
    .start  (st_reg.lock_start),
    .locked (locked)
  );

  always_comb begin
    st_next = st_reg;
    st_next.lock_start = 1'b0;
    st_next.isr        = 1'b0;
    st_next.resume     = 1'b0;

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    if (s_axi_awvalid && !st_reg.aw_got) begin
      st_next.aw_got  = 1'b1;
      st_next.wr.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got) begin
      st_next.w_got   = 1'b1;
      st_next.wr.data = s_axi_wdata;
      st_next.wr.strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = 2'b00;
      case (st_reg.wr.addr[11:2])
        IDX_CSR: begin
          for (int i = 0; i < 4; i++) begin
            if (st_reg.wr.strb[i]) begin
              st_next.control_status_reg[i*8 +: 8] = st_reg.wr.data[i*8 +: 8];
            end
          end
          if (st_reg.wr.strb[1]) begin
            st_next.dly = `PCC_SLEEP_DLY;
          end
        end
        IDX_IER: begin
          for (int i = 0; i < 4; i++) begin
            if (st_reg.wr.strb[i]) begin
              st_next.int_enable_reg[i*8 +: 8] = st_reg.wr.data[i*8 +: 8];
            end
          end
        end
        IDX_CFG: begin
          if (st_reg.wr.strb[0]) begin
            st_next.pll_multiplier_select = st_reg.wr.data[0];
            if (st_reg.wr.data[3:1] <= `PCC_RANGE_MAX) begin
              st_next.pll_range_select = st_reg.wr.data[3:1];
            end
            st_next.lock_start = st_reg.wr.data[0];
          end
        end
        default: begin
          st_next.bresp = 2'b10;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    st_next.arready = 1'b0;
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = 2'b00;
      case (s_axi_araddr[11:2])
        IDX_CSR:  st_next.rdata = st_reg.control_status_reg;
        IDX_IER:  st_next.rdata = st_reg.int_enable_reg;
        IDX_CFG:  st_next.rdata = {28'h0000000,
                              st_reg.pll_range_select,
                              st_reg.pll_multiplier_select};
        IDX_STAT: st_next.rdata = {28'h0000000, locked,
                              st_reg.fsm};
        IDX_WAKE: st_next.rdata = {30'h00000000,
                              st_reg.wake_isr, st_reg.wake_seen};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = 2'b10;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // power-down sequencer
    // ----------------------------------------------------------------
    case (st_reg.fsm)
      PCC_RUN: begin
        if (csr_wr) begin
          st_next.fsm = PCC_ARM;
        end else if (lock_restart) begin
          // gate the cpu clock at once, not only once lock drops
          st_next.fsm = PCC_LOCK;
        end
      end
      PCC_ARM: begin
        if (st_reg.dly > 4'h1) begin
          st_next.dly = st_reg.dly - 4'h1;
        end else begin
          case (pd_code)
            `PCC_CODE_SLP_EN,
            `PCC_CODE_SLP_ANY:  st_next.fsm = PCC_SLEEP;
            `PCC_CODE_OUT_STOP: st_next.fsm = PCC_OUT_STOP;
            `PCC_CODE_IN_STOP:  st_next.fsm = PCC_IN_STOP;
            default:            st_next.fsm = PCC_RUN;
          endcase
        end
      end
      PCC_SLEEP: begin
        if (int_enabled || (int_any
            && pd_code == `PCC_CODE_SLP_ANY)) begin
          st_next.fsm       = PCC_RUN;
          st_next.wake_seen = 1'b1;
          st_next.control_status_reg[`PCC_PD_MSB:`PCC_PD_LSB] =
            `PCC_CODE_NONE;
          st_next.resume    = 1'b1;
          st_next.isr       = int_enabled && int_ok;
          st_next.wake_isr  = int_enabled && int_ok;
        end
      end
      PCC_OUT_STOP,
      PCC_IN_STOP: begin
        st_next.fsm = st_reg.fsm;
      end
      PCC_LOCK: begin
        // stale lock flag still high in the cycle of a restart
        if (locked && !st_reg.lock_start) begin
          st_next.fsm = PCC_RUN;
        end
      end
      default: st_next.fsm = PCC_RUN;
    endcase

    // ----------------------------------------------------------------
    // clock outputs
    // ----------------------------------------------------------------
    st_next.cpu_en = (st_reg.fsm == PCC_RUN || st_reg.fsm == PCC_ARM)
                   && clk_s.cpu_ce;
    st_next.dma_en = (st_next.fsm == PCC_RUN || st_next.fsm == PCC_ARM
                   || st_next.fsm == PCC_SLEEP) && locked
                   && dma_req;
    if (running && locked) begin
      // frozen outputs hold last level in deep states
      st_next.cpu_out  = clk_s.cpu_ce ? ~st_reg.cpu_out
                                      : st_reg.cpu_out;
      st_next.half_out = clk_s.half_ce ? ~st_reg.half_out
                                       : st_reg.half_out;
    end
    // ready flags registered from the next capture state
    st_next.awready = !st_next.aw_got;
    st_next.wready  = !st_next.w_got;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg                       <= '0;
      st_reg.fsm                   <= PCC_LOCK;
      st_reg.control_status_reg    <= `PCC_CSR_RST;
      st_reg.pll_multiplier_select <= CFG_RST[0];
      st_reg.pll_range_select      <= CFG_RST[3:1];
      st_reg.awready               <= 1'b1;
      st_reg.wready                <= 1'b1;
      st_reg.lock_start            <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready       = st_reg.awready;
  assign s_axi_wready        = st_reg.wready;
  assign s_axi_bvalid        = st_reg.bvalid;
  assign s_axi_bresp         = st_reg.bresp;
  assign s_axi_arready       = st_reg.arready;
  assign s_axi_rvalid        = st_reg.rvalid;
  assign s_axi_rdata         = st_reg.rdata;
  assign s_axi_rresp         = st_reg.rresp;
  assign cpu_clock_out       = st_reg.cpu_out;
  assign half_rate_clock_out = st_reg.half_out;
  assign cpu_clk_en          = st_reg.cpu_en;
  assign dma_clk_en          = st_reg.dma_en;
  assign isr_req             = st_reg.isr;
  assign resume_req          = st_reg.resume;
endmodule : pcc_top
`default_nettype wire

// ---- dv/pcc_top_properties.sv ----
// port checker of the clock and power-down controller
`timescale 1ns/1ps
`default_nettype none
module pcc_top_properties #(
  parameter int unsigned LOCK_CYC = 20
) (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        dma_req,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_clock_out,
  input wire logic        half_rate_clock_out,
  input wire logic        cpu_clk_en,
  input wire logic        dma_clk_en,
  input wire logic        isr_req,
  input wire logic        resume_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // cycles since reset release, saturating
  int unsigned rst_cnt;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) rst_cnt <= 0;
    else if (rst_cnt < LOCK_CYC) rst_cnt <= rst_cnt + 1;

  a_lock_quiet: assert property (
    rst_cnt < LOCK_CYC - 1 |-> !cpu_clk_en)
    else $error("cpu clock enabled during lock wait");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_r_answer: assert property (
    $rose(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  a_wake_pulse: assert property (
    resume_req |=> !resume_req) else $error("resume not a pulse");
  a_isr_wake: assert property (
    isr_req |-> resume_req) else $error("service without wake");
  a_dma_cause: assert property (
    dma_clk_en |-> $past(dma_req)) else $error("dma clock without request");
  a_half_rate: assert property (
    $changed(half_rate_clock_out) |-> $changed(cpu_clock_out))
    else $error("half rate clock off its tick");
endmodule : pcc_top_properties

bind pcc_top pcc_top_properties #(.LOCK_CYC(LOCK_CYC)) i_pcc_top_properties (
  .mclk, .arst_n, .dma_req, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .cpu_clock_out, .half_rate_clock_out, .cpu_clk_en, .dma_clk_en,
  .isr_req, .resume_req);
`default_nettype wire

// ---- dv/pcc_partner_model.sv ----
// oscillator and interrupt sources facing the controller
`timescale 1ns/1ps
`default_nettype none
module pcc_partner_model #(
  parameter int HALF = 4
) (
  input  wire logic mclk,
  input  wire logic raise_en,
  input  wire logic raise_any,
  input  wire logic resume_req,
  output logic      ref_clock_in,
  output logic      int_enabled,
  output logic      int_any
);
  int   cnt   = 0;
  logic ref_q = 1'b0;
  logic en_q  = 1'b0;
  logic any_q = 1'b0;
  assign ref_clock_in = ref_q;
  assign int_enabled  = en_q;
  assign int_any      = any_q;
  // free running reference oscillator
  always @(posedge mclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) ref_q <= ~ref_q;
  end
  // pending until the core takes the wake
  always @(posedge mclk) begin
    if (raise_en || raise_any) any_q <= 1'b1;
    else if (resume_req) any_q <= 1'b0;
    if (raise_en) en_q <= 1'b1;
    else if (resume_req) en_q <= 1'b0;
  end
endmodule : pcc_partner_model
`default_nettype wire

// ---- dv/test_pll_clock_and_powerdown_control.sv ----
// self-checking bench of the clock and power-down controller
`timescale 1ns/1ps
`default_nettype none
module test_pll_clock_and_powerdown_control;
  localparam int LC = 20;
  logic mclk = 1'b0, arst_n = 1'b0, dma_req = 1'b0;
  logic raise_en = 1'b0, raise_any = 1'b0;
  logic ref_clock_in, int_enabled, int_any;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_clock_out, half_rate_clock_out, cpu_clk_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic dma_clk_en, isr_req, resume_req;
  int n_mismatch = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  pcc_top #(.LOCK_CYC(LC)) i_pcc_top (.*);
  pcc_partner_model i_pcc_partner_model (.*);

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic hang;
    n_mismatch++;
    wrap_up();
  endtask : hang
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) hang();
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) hang();
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // count edges until the cpu clock runs
  task automatic run_wait(output int n);
    n = 0;
    while (cpu_clk_en !== 1'b1) begin
      if (n == 200) hang();
      @(posedge mclk);
      n++;
    end
  endtask : run_wait
  task automatic pulse(input logic en);
    @(posedge mclk);
    if (en) raise_en <= 1'b1;
    else raise_any <= 1'b1;
    @(posedge mclk);
    raise_en <= 1'b0;
    raise_any <= 1'b0;
  endtask : pulse

  task automatic t_lock;
    int n;
    arst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    run_wait(n);
    chk(32'(n >= LC), 32'h1);
    rd(12'h00C);
    chk(v[3:0], 4'h8);
    rd(12'h008);
    chk(v, 32'h1);
    $display("lock test done");
  endtask : t_lock
  task automatic t_bus;
    wr(12'h020, 32'hFFFF_FFFF);
    chk(r, 2'b10);
    rd(12'h020);
    chk(r, 2'b10);
    chk(v, 32'h0);
    $display("bus test done");
  endtask : t_bus
  task automatic t_mult;
    int n, nc, nh;
    logic [1:0] p;
    wr(12'h008, 32'hE);
    n = 0;
    repeat (80) @(posedge mclk) n += cpu_clk_en;
    chk(32'(n >= 9 && n <= 11), 32'h1);
    rd(12'h008);
    chk(v, 32'h0);
    wr(12'h008, 32'h5);
    rd(12'h00C);
    chk(v[3:0], 4'h5);
    run_wait(n);
    rd(12'h008);
    chk(v, 32'h5);
    n = 0;
    nc = 0;
    nh = 0;
    p = {cpu_clock_out, half_rate_clock_out};
    repeat (40) @(posedge mclk) begin
      n += cpu_clk_en;
      nc += p[1] ^ cpu_clock_out;
      nh += p[0] ^ half_rate_clock_out;
      p = {cpu_clock_out, half_rate_clock_out};
    end
    chk(n, 40);
    chk(nc, 40);
    chk(nh, 20);
    $display("multiplier test done");
  endtask : t_mult
  task automatic t_sleep(input logic [5:0] c, input logic global_int_enable, nmi_enable_bit, en, wk);
    int n;
    logic res, isr, want;
    want = global_int_enable & nmi_enable_bit & (en | !wk);
    wr(12'h004, {30'h0, nmi_enable_bit, 1'b0});
    wr(12'h000, {16'h0, c, 9'h0, global_int_enable});
    for (n = 0; cpu_clk_en !== 1'b0 && n < 20; n++) @(posedge mclk);
    chk(32'(n >= 7 && n <= 10), 32'h1);
    dma_req <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({dma_clk_en, cpu_clk_en}, 2'b10);
    dma_req <= 1'b0;
    pulse(en);
    if (!wk) begin
      repeat (12) @(posedge mclk);
      rd(12'h00C);
      chk(v[2:0], 3'h2);
      pulse(1'b1);
    end
    res = 1'b0;
    isr = 1'b0;
    repeat (12) @(posedge mclk) begin
      res |= resume_req;
      isr |= isr_req;
    end
    chk({res, isr}, {1'b1, want});
    rd(12'h010);
    chk(v, {30'h0, want, 1'b1});
    rd(12'h00C);
    chk(v[2:0], 3'h0);
    $display("sleep test %h done", c);
  endtask : t_sleep
  task automatic t_resv(input logic [5:0] c);
    wr(12'h000, {16'h0, c, 10'h0});
    repeat (12) @(posedge mclk);
    rd(12'h00C);
    chk({cpu_clk_en, v[2:0]}, 4'h8);
  endtask : t_resv
  task automatic t_deep(input logic [5:0] c, input logic [2:0] st);
    logic [1:0] hold;
    wr(12'h000, {16'h0, c, 10'h0});
    repeat (12) @(posedge mclk);
    hold = {cpu_clock_out, half_rate_clock_out};
    dma_req <= 1'b1;
    pulse(1'b1);
    repeat (10) @(posedge mclk);
    chk({cpu_clock_out, half_rate_clock_out}, hold);
    chk({dma_clk_en, cpu_clk_en, resume_req}, 3'h0);
    dma_req <= 1'b0;
    rd(12'h00C);
    chk(v[2:0], st);
    $display("deep test %h done", c);
    t_lock();
  endtask : t_deep

  initial begin
    t_lock();
    t_bus();
    t_mult();
    t_sleep(6'h09, 1'b1, 1'b1, 1'b1, 1'b1);
    t_sleep(6'h09, 1'b0, 1'b1, 1'b1, 1'b1);
    t_sleep(6'h09, 1'b1, 1'b1, 1'b0, 1'b0);
    t_sleep(6'h11, 1'b1, 1'b1, 1'b0, 1'b1);
    t_sleep(6'h11, 1'b1, 1'b0, 1'b1, 1'b1);
    t_resv(6'h05);
    t_resv(6'h12);
    t_resv(6'h1F);
    $display("reserved test done");
    t_deep(6'h1A, 3'h3);
    t_deep(6'h1C, 3'h4);
    wrap_up();
  end
endmodule : test_pll_clock_and_powerdown_control
`default_nettype wire
